/* File: src/afc_pkg.sv */
// constants and register map for the analog frequency command selector
//
// Contract
// - terminal 2 voltage input, full scale 5 V (default) or 10 V
// - terminal 4 type: 0 gives 4-20 mA (default), 1 0-5 V, 2 0-10 V
// - terminal 4 commands only while its enable is on; terminal 2 then steps aside
// - terminal 4 enable comes from any input terminal assigned function code 4
// - range select 10 or 11 allows reversible operation; 0 and 1 do not
// - reversible 5 V with bias at half gain: below 2.5 V reverse, above forward
// - reversible terminal 4 by default: 0-4 mA reverse, 4-20 mA forward
// - thermistor level other than 9999 blocks terminal 2 as command source
// - full-scale terminal 2 voltage maps to the gain frequency
// - first-order delay filter, setting 0 to 8, default 1, about 5 ms to 1 s
// - changing the range select leaves acceleration and deceleration times alone
// - terminal 4 is a voltage input for type 1 or 2 with switch on voltage
// - gain frequency alone sets the frequency at full input, no input needed
// - terminal 2 gain frequency, default 60 Hz, range 0 to 400 Hz
// - terminal 2 bias frequency, default 0 Hz, at the bias-side input level
package afc_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // register port
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_THERM = 8'h04;
  localparam logic [7:0] OFS_T2_GAIN_F = 8'h08;
  localparam logic [7:0] OFS_T2_BIAS_F = 8'h0c;
  localparam logic [7:0] OFS_T2_BIAS_P = 8'h10;
  localparam logic [7:0] OFS_T2_GAIN_P = 8'h14;
  localparam logic [7:0] OFS_T4_GAIN_F = 8'h18;
  localparam logic [7:0] OFS_T4_BIAS_F = 8'h1c;
  localparam logic [7:0] OFS_T4_BIAS_P = 8'h20;
  localparam logic [7:0] OFS_T4_GAIN_P = 8'h24;
  localparam logic [7:0] OFS_ASSIGN = 8'h28;
  localparam logic [7:0] OFS_STATUS = 8'h2c;

  // control register fields
  localparam int CTRL_RANGE_LSB = 0;
  localparam int CTRL_T4TYPE_LSB = 8;
  localparam int CTRL_FILT_LSB = 12;

  // status register fields
  localparam int STAT_REV_BIT = 16;
  localparam int STAT_T4EN_BIT = 17;
  localparam int STAT_INH_BIT = 18;
  localparam int STAT_MISM_BIT = 19;

  //////////////////////////////////////////////////////////////////////////////
  // setting codes and reset values (frequency in 0.01 Hz, percent in 0.1 %)
  localparam logic [7:0] RANGE_10V = 8'h00;
  localparam logic [7:0] RANGE_5V = 8'h01;
  localparam logic [7:0] RANGE_10V_REV = 8'h0a;
  localparam logic [7:0] RANGE_5V_REV = 8'h0b;
  localparam logic [1:0] T4_CURRENT = 2'h0;
  localparam logic [1:0] T4_5V = 2'h1;
  localparam logic [1:0] T4_10V = 2'h2;
  localparam logic [3:0] FILT_DEFAULT = 4'h1;
  localparam logic [3:0] FILT_MAX = 4'h8;
  localparam logic [15:0] THERM_OFF = 16'h270f;
  localparam logic [15:0] GAIN_F_DEFAULT = 16'h1770;
  localparam logic [15:0] BIAS_F_DEFAULT = 16'h0000;
  localparam logic [15:0] FREQ_MAX = 16'h9c40;
  localparam logic [11:0] T2_BIAS_P_DEFAULT = 12'h000;
  localparam logic [11:0] T4_BIAS_P_DEFAULT = 12'h0c8;
  localparam logic [11:0] GAIN_P_DEFAULT = 12'h3e8;
  localparam logic [3:0] FUNC_T4_ENABLE = 4'h4;
  localparam int N_TERMS = 5;
  localparam int ASSIGN_W = 4;
  localparam logic [19:0] ASSIGN_DEFAULT = 20'h43210;

  //////////////////////////////////////////////////////////////////////////////
  // sampling and scaling
  localparam int CODE_W = 12;
  localparam int PCT_FULL = 1000;
  localparam int FRAC_W = 8;
  localparam int CLK_PERIOD_PS = 5000;
  localparam longint SAMPLE_PERIOD_PS = 64'd2500000000;
  localparam int SAMPLE_CYCLES_DFLT = int'(SAMPLE_PERIOD_PS / CLK_PERIOD_PS);
  localparam int DIV_W = 19;

endpackage : afc_pkg

/* File: src/afc_filt_if.sv */
// carrier between the command selector and its delay filter
`timescale 1ns/1ps
`default_nettype none
interface afc_filt_if;
  import afc_pkg::*;
  logic tick;
  logic [CODE_W-1:0] x;
  logic [3:0] shift;
  logic [CODE_W-1:0] y;
  logic y_valid;
  modport sel (output tick, output x, output shift, input y, input y_valid);
  modport filt (input tick, input x, input shift, output y, output y_valid);
endinterface : afc_filt_if
`default_nettype wire

/* File: src/afc_delay_filter.sv */
// first-order recursive delay filter, one update per sample tick
`timescale 1ns/1ps
`default_nettype none
module afc_delay_filter
  import afc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // filter carrier
  afc_filt_if.filt f
);

  typedef struct packed {
    logic signed [CODE_W+FRAC_W:0] acc;
    logic valid;
  } afc_filt_state_t;

  afc_filt_state_t s_r;
  afc_filt_state_t s_nxt;

  always_comb begin
    logic signed [CODE_W+FRAC_W:0] tgt;
    tgt = $signed({1'b0, f.x, {FRAC_W{1'b0}}});
    s_nxt = s_r;
    s_nxt.valid = 1'b0;
    if (rst) begin
      s_nxt = '0;
    end else if (f.tick) begin
      // fractional bits keep long time constants from stalling more than two counts short of target
      s_nxt.acc = s_r.acc + ((tgt - s_r.acc) >>> f.shift);
      s_nxt.valid = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    s_r <= s_nxt;
  end

  assign f.y = s_r.acc[CODE_W+FRAC_W-1:FRAC_W];
  assign f.y_valid = s_r.valid;

endmodule : afc_delay_filter
`default_nettype wire

/* File: src/afc_analog_cmd_sel.sv */
// analog frequency command selector: range select, scaling, filter, interpolation
`timescale 1ns/1ps
`default_nettype none
module afc_analog_cmd_sel
  import afc_pkg::*;
#(
  parameter int SAMPLE_CYCLES = SAMPLE_CYCLES_DFLT
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // digitised analog inputs, 0 to full scale of the converter
  input wire logic [CODE_W-1:0] t2_code,
  input wire logic [CODE_W-1:0] t4_code,
  // general input terminals and the terminal 4 selector position
  input wire logic [N_TERMS-1:0] input_terms,
  input wire logic t4_switch_voltage,
  // frequency command
  output logic [15:0] freq_cmd,
  output logic freq_reverse,
  output logic freq_update,
  output logic terminal4_enable_signal,
  output logic t2_inhibited
);

  typedef struct packed {
    logic [7:0] analog_range_select;
    logic [1:0] t4_input_type_select;
    logic [3:0] input_filter_setting;
    logic [15:0] thermistor_level_setting;
    logic [15:0] t2_gain_frequency;
    logic [15:0] t2_bias_frequency;
    logic [11:0] t2_bias_percent;
    logic [11:0] t2_gain_percent;
    logic [15:0] t4_gain_frequency;
    logic [15:0] t4_bias_frequency;
    logic [11:0] t4_bias_percent;
    logic [11:0] t4_gain_percent;
    logic [N_TERMS*ASSIGN_W-1:0] input_function_assign;
    logic [DIV_W-1:0] div_cnt;
    logic [31:0] rdata;
    logic [15:0] freq;
    logic rev;
    logic upd;
    logic t4_en;
    logic t2_inh;
    logic mismatch;
    logic src_t4;
  } afc_state_t;

  afc_state_t s_r;
  afc_state_t s_nxt;

  afc_filt_if filt_bus ();

  afc_delay_filter u_filter (
    .ref_clk(ref_clk),
    .rst(rst),
    .f(filt_bus)
  );

  //////////////////////////////////////////////////////////////////////////////
  // converts a raw code to 0.1 % of the selected range; a half-range input
  // reads double, so a 5 V range reaches full scale at mid code
  function automatic logic [CODE_W-1:0] to_percent(input logic [CODE_W-1:0] code,
                                                    input logic half);
    logic [CODE_W:0] v;
    logic [CODE_W+10:0] p;
    v = half ? {code, 1'b0} : {1'b0, code};
    p = (CODE_W+11)'(v) * (CODE_W+11)'(PCT_FULL);
    return p[CODE_W+10:CODE_W] > (CODE_W+11-CODE_W)'(PCT_FULL * 2)
      ? CODE_W'(PCT_FULL * 2) : CODE_W'(p[CODE_W+10:CODE_W]);
  endfunction : to_percent

  //////////////////////////////////////////////////////////////////////////////
  // input selection
  logic [N_TERMS-1:0] term_hit;
  logic t4_en;
  logic use_half;
  logic reversible;
  logic t2_block;
  logic tick;

  // each terminal is matched alone, so any one carrying the code enables terminal 4
  for (genvar i = 0; i < N_TERMS; i++) begin : g_term
    assign term_hit[i] = input_terms[i] &&
        s_r.input_function_assign[i*ASSIGN_W +: ASSIGN_W] == FUNC_T4_ENABLE;
  end
  assign t4_en = |term_hit;

  // range select only steers scaling and reversibility; ramp times live elsewhere and stay put
  assign reversible = s_r.analog_range_select == RANGE_10V_REV ||
                      s_r.analog_range_select == RANGE_5V_REV;
  assign use_half = t4_en ? (s_r.t4_input_type_select == T4_5V)
                          : s_r.analog_range_select[0];
  assign t2_block = !t4_en && s_r.thermistor_level_setting != THERM_OFF;
  assign tick = s_r.div_cnt == DIV_W'(SAMPLE_CYCLES - 1);

  assign filt_bus.tick = tick;
  assign filt_bus.x = to_percent(t4_en ? t4_code : t2_code, use_half);
  assign filt_bus.shift = (s_r.input_filter_setting > FILT_MAX ? FILT_MAX
                           : s_r.input_filter_setting) + 4'h1;

  //////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic signed [31:0] dx;
    logic signed [31:0] df;
    logic signed [31:0] den;
    logic signed [31:0] fr;
    logic [15:0] bf;
    logic [15:0] gf;
    logic [11:0] bp;
    logic [11:0] gp;
    dx = '0;
    df = '0;
    den = '0;
    fr = '0;
    bf = s_r.src_t4 ? s_r.t4_bias_frequency : s_r.t2_bias_frequency;
    gf = s_r.src_t4 ? s_r.t4_gain_frequency : s_r.t2_gain_frequency;
    bp = s_r.src_t4 ? s_r.t4_bias_percent : s_r.t2_bias_percent;
    gp = s_r.src_t4 ? s_r.t4_gain_percent : s_r.t2_gain_percent;
    s_nxt = s_r;
    s_nxt.upd = 1'b0;
    s_nxt.t4_en = t4_en;
    s_nxt.t2_inh = t2_block;
    s_nxt.mismatch = (s_r.t4_input_type_select != T4_CURRENT) != t4_switch_voltage;
    s_nxt.div_cnt = tick ? '0 : s_r.div_cnt + DIV_W'(1);
    if (tick) begin
      s_nxt.src_t4 = t4_en;
    end

    // interpolation on the filtered sample
    if (filt_bus.y_valid) begin
      dx = $signed({20'h0, filt_bus.y}) - $signed({20'h0, bp});
      df = $signed({16'h0, gf}) - $signed({16'h0, bf});
      den = $signed({20'h0, gp}) - $signed({20'h0, bp});
      fr = $signed({16'h0, bf}) + ((den == 0) ? 32'sh0 : (dx * df) / den);
      if (!reversible && dx < 0) begin
        fr = $signed({16'h0, bf});
      end
      s_nxt.upd = 1'b1;
      s_nxt.rev = 1'b0;
      if (s_r.t2_inh) begin
        fr = '0;
      end else if (fr < 0) begin
        // below the bias point only a reversible range turns the motor back
        s_nxt.rev = reversible;
        fr = reversible ? -fr : 32'sh0;
      end
      s_nxt.freq = fr > $signed({16'h0, FREQ_MAX}) ? FREQ_MAX : fr[15:0];
    end

    // register writes
    if (reg_wr) begin
      unique case (reg_addr)
        OFS_CTRL: begin
          s_nxt.analog_range_select = reg_wdata[CTRL_RANGE_LSB +: 8];
          s_nxt.t4_input_type_select = reg_wdata[CTRL_T4TYPE_LSB +: 2];
          s_nxt.input_filter_setting = reg_wdata[CTRL_FILT_LSB +: 4];
        end
        OFS_THERM: s_nxt.thermistor_level_setting = reg_wdata[15:0];
        OFS_T2_GAIN_F: s_nxt.t2_gain_frequency = reg_wdata[15:0];
        OFS_T2_BIAS_F: s_nxt.t2_bias_frequency = reg_wdata[15:0];
        OFS_T2_BIAS_P: s_nxt.t2_bias_percent = reg_wdata[11:0];
        OFS_T2_GAIN_P: s_nxt.t2_gain_percent = reg_wdata[11:0];
        OFS_T4_GAIN_F: s_nxt.t4_gain_frequency = reg_wdata[15:0];
        OFS_T4_BIAS_F: s_nxt.t4_bias_frequency = reg_wdata[15:0];
        OFS_T4_BIAS_P: s_nxt.t4_bias_percent = reg_wdata[11:0];
        OFS_T4_GAIN_P: s_nxt.t4_gain_percent = reg_wdata[11:0];
        OFS_ASSIGN: s_nxt.input_function_assign = reg_wdata[N_TERMS*ASSIGN_W-1:0];
        default: ;
      endcase
    end

    // register reads, answered in the following cycle
    s_nxt.rdata = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_CTRL: begin
          s_nxt.rdata[CTRL_RANGE_LSB +: 8] = s_r.analog_range_select;
          s_nxt.rdata[CTRL_T4TYPE_LSB +: 2] = s_r.t4_input_type_select;
          s_nxt.rdata[CTRL_FILT_LSB +: 4] = s_r.input_filter_setting;
        end
        OFS_THERM: s_nxt.rdata[15:0] = s_r.thermistor_level_setting;
        OFS_T2_GAIN_F: s_nxt.rdata[15:0] = s_r.t2_gain_frequency;
        OFS_T2_BIAS_F: s_nxt.rdata[15:0] = s_r.t2_bias_frequency;
        OFS_T2_BIAS_P: s_nxt.rdata[11:0] = s_r.t2_bias_percent;
        OFS_T2_GAIN_P: s_nxt.rdata[11:0] = s_r.t2_gain_percent;
        OFS_T4_GAIN_F: s_nxt.rdata[15:0] = s_r.t4_gain_frequency;
        OFS_T4_BIAS_F: s_nxt.rdata[15:0] = s_r.t4_bias_frequency;
        OFS_T4_BIAS_P: s_nxt.rdata[11:0] = s_r.t4_bias_percent;
        OFS_T4_GAIN_P: s_nxt.rdata[11:0] = s_r.t4_gain_percent;
        OFS_ASSIGN: s_nxt.rdata[N_TERMS*ASSIGN_W-1:0] = s_r.input_function_assign;
        OFS_STATUS: begin
          s_nxt.rdata[15:0] = s_r.freq;
          s_nxt.rdata[STAT_REV_BIT] = s_r.rev;
          s_nxt.rdata[STAT_T4EN_BIT] = s_r.t4_en;
          s_nxt.rdata[STAT_INH_BIT] = s_r.t2_inh;
          // a selector that disagrees with the type setting is only reported
          s_nxt.rdata[STAT_MISM_BIT] = s_r.mismatch;
        end
        default: ;
      endcase
    end

    if (rst) begin
      s_nxt = '0;
      s_nxt.analog_range_select = RANGE_5V;
      s_nxt.t4_input_type_select = T4_CURRENT;
      s_nxt.input_filter_setting = FILT_DEFAULT;
      s_nxt.thermistor_level_setting = THERM_OFF;
      s_nxt.t2_gain_frequency = GAIN_F_DEFAULT;
      s_nxt.t2_bias_frequency = BIAS_F_DEFAULT;
      s_nxt.t2_bias_percent = T2_BIAS_P_DEFAULT;
      s_nxt.t2_gain_percent = GAIN_P_DEFAULT;
      s_nxt.t4_gain_frequency = GAIN_F_DEFAULT;
      s_nxt.t4_bias_frequency = BIAS_F_DEFAULT;
      s_nxt.t4_bias_percent = T4_BIAS_P_DEFAULT;
      s_nxt.t4_gain_percent = GAIN_P_DEFAULT;
      s_nxt.input_function_assign = ASSIGN_DEFAULT;
    end
  end

  always_ff @(posedge ref_clk) begin
    s_r <= s_nxt;
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs
  assign reg_rdata = s_r.rdata;
  assign freq_cmd = s_r.freq;
  assign freq_reverse = s_r.rev;
  assign freq_update = s_r.upd;
  assign terminal4_enable_signal = s_r.t4_en;
  assign t2_inhibited = s_r.t2_inh;

endmodule : afc_analog_cmd_sel
`default_nettype wire

/* File: testbench/afc_cmd_chk.sv */
// port assertions for the analog command selector
`timescale 1ns/1ps
`default_nettype none
module afc_cmd_chk
  import afc_pkg::*;
#(
  parameter int SAMPLE_CYCLES = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // inputs and command
  input wire logic [N_TERMS-1:0] input_terms,
  input wire logic [15:0] freq_cmd,
  input wire logic freq_reverse,
  input wire logic freq_update,
  input wire logic terminal4_enable_signal,
  input wire logic t2_inhibited
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  //////////////////////////////////////////////////////////////////////////////
  upd_pulse_a:
    assert property (freq_update |=> !freq_update) else $error("update pulse too long");
  upd_period_a:
    assert property (freq_update |-> ##SAMPLE_CYCLES freq_update) else $error("update late");
  cmd_hold_a:
    assert property (!freq_update |-> $stable(freq_cmd) && $stable(freq_reverse))
      else $error("command moved between updates");
  cmd_max_a:
    assert property (freq_cmd <= FREQ_MAX) else $error("command above limit");
  rev_mag_a:
    assert property (freq_reverse |-> freq_cmd != 16'h0) else $error("reverse at zero");
  t4en_idle_a:
    assert property ($past(input_terms) == 5'h0 |-> !terminal4_enable_signal)
      else $error("terminal 4 enabled with no input");
  inhib_zero_a:
    assert property (freq_update && $past(t2_inhibited) |-> freq_cmd == 16'h0 && !freq_reverse)
      else $error("inhibited terminal 2 still commands");
  inhib_t4_a:
    assert property (terminal4_enable_signal ##1 terminal4_enable_signal |-> !t2_inhibited)
      else $error("terminal 2 inhibit with terminal 4 selected");
endmodule : afc_cmd_chk
`default_nettype wire

/* File: testbench/afc_sig_source.sv */
// analog source model: potentiometer or adjuster seen through the converter
`timescale 1ns/1ps
`default_nettype none
module afc_sig_source
  import afc_pkg::*;
(
  // clock
  input wire logic ref_clk,
  // wanted levels and turn speed
  input wire logic [CODE_W-1:0] t2_level,
  input wire logic [CODE_W-1:0] t4_level,
  input wire logic slow,
  // converter codes
  output logic [CODE_W-1:0] t2_code,
  output logic [CODE_W-1:0] t4_code
);
  // a slow source walks 8 codes a clock, like a knob being turned
  function automatic logic [CODE_W-1:0] walk(input logic [CODE_W-1:0] c,
                                             input logic [CODE_W-1:0] t);
    if (int'(t) > int'(c) + 8) return c + 12'h8;
    if (int'(c) > int'(t) + 8) return c - 12'h8;
    return t;
  endfunction : walk
  // codes are unknown only until the first edge, which falls well inside reset
  always @(posedge ref_clk) begin
    t2_code <= slow ? walk(t2_code, t2_level) : t2_level;
    t4_code <= slow ? walk(t4_code, t4_level) : t4_level;
  end
endmodule : afc_sig_source
`default_nettype wire

/* File: testbench/test_analog_frequency_command_select.sv */
// self-checking bench for the analog frequency command selector
`timescale 1ns/1ps
`default_nettype none
module test_analog_frequency_command_select;
  import afc_pkg::*;
  localparam int SC = 16;
  localparam logic [7:0] RA [7] = '{OFS_CTRL, OFS_THERM, OFS_T2_GAIN_F, OFS_T2_BIAS_F,
                                    OFS_T4_BIAS_P, OFS_ASSIGN, 8'h30};
  localparam logic [31:0] RV [7] = '{32'h1001, 32'h270f, 32'h1770, 32'h0, 32'hc8,
                                     32'h43210, 32'h0};
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [CODE_W-1:0] t2_code, t4_code;
  logic [CODE_W-1:0] t2_level = 12'h0;
  logic [CODE_W-1:0] t4_level = 12'h0;
  logic [N_TERMS-1:0] input_terms = 5'h0;
  logic t4_switch_voltage = 1'b0;
  logic slow = 1'b0;
  logic [15:0] freq_cmd;
  logic freq_reverse, freq_update, terminal4_enable_signal, t2_inhibited;
  logic [31:0] rd;
  int fails = 0;
  int checks = 0;

  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end

  afc_analog_cmd_sel #(.SAMPLE_CYCLES(SC)) DUT (.ref_clk, .rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .t2_code, .t4_code, .input_terms, .t4_switch_voltage,
    .freq_cmd, .freq_reverse, .freq_update, .terminal4_enable_signal, .t2_inhibited);
  afc_sig_source src (.ref_clk, .t2_level, .t4_level, .slow, .t2_code, .t4_code);

  //////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (fails == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp32

  task automatic cmp_bit(input logic got, input logic exp);
    cmp32({31'h0, got}, {31'h0, exp});
  endtask : cmp_bit

  // the filter settles one count short of its target, so magnitudes get a margin
  task automatic cmp_near(input logic [15:0] got, input logic [15:0] exp, input int tol);
    int d;
    d = int'(got) - int'(exp);
    checks++;
    if ((^got === 1'bx) || d > tol || d < -tol) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_near

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd_reg

  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : wait_clk

  task automatic wait_upd(input int n);
    int k;
    k = 0;
    while (n > 0) begin
      wait_clk(1);
      k++;
      if (freq_update === 1'b1) n--;
      if (k > 200 * SC) begin
        fails++;
        tally_and_finish();
      end
    end
  endtask : wait_upd

  task automatic chk(input logic [15:0] exp, input logic rev);
    wait_upd(40);
    cmp_near(freq_cmd, exp, 20);
    cmp_bit(freq_reverse, rev);
  endtask : chk

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      rd_reg(RA[i], rd);
      cmp32(rd, RV[i]);
    end
    wr_reg(OFS_CTRL, 32'h1);
    t2_level <= 12'h800;
    chk(16'd6000, 1'b0);
    wr_reg(OFS_CTRL, 32'h0);
    chk(16'd3000, 1'b0);
    wr_reg(OFS_T2_GAIN_F, 32'd12000);
    t2_level <= 12'hfff;
    chk(16'd11988, 1'b0);
    wr_reg(OFS_T2_GAIN_F, 32'd6000);
    // reversible 5 V range with bias at half of gain
    wr_reg(OFS_T2_BIAS_P, 32'd500);
    wr_reg(OFS_CTRL, 32'hb);
    t2_level <= 12'h200;
    chk(16'd3000, 1'b1);
    // a lost input on a reversible range drives the motor backwards at full speed
    t2_level <= 12'h0;
    chk(16'd6000, 1'b1);
    slow <= 1'b1;
    t2_level <= 12'h600;
    chk(16'd3000, 1'b0);
    slow <= 1'b0;
    wr_reg(OFS_CTRL, 32'h1);
    t2_level <= 12'h200;
    chk(16'd0, 1'b0);
    wr_reg(OFS_T2_BIAS_P, 32'd0);
    t2_level <= 12'hfff;
    input_terms <= 5'h10;
    wr_reg(OFS_CTRL, 32'ha);
    t4_level <= 12'd409;
    chk(16'd757, 1'b1);
    cmp_bit(terminal4_enable_signal, 1'b1);
    t4_level <= 12'd2457;
    chk(16'd2992, 1'b0);
    for (int t = 1; t < 3; t++) begin
      wr_reg(OFS_CTRL, 32'(t) << 8);
      t4_switch_voltage <= 1'b1;
      t4_level <= 12'(1024 * t);
      chk(16'd2250, 1'b0);
    end
    wr_reg(OFS_ASSIGN, 32'h03214);
    rd_reg(OFS_ASSIGN, rd);
    cmp32(rd, 32'h03214);
    wait_clk(2);
    cmp_bit(terminal4_enable_signal, 1'b0);
    @(posedge ref_clk);
    input_terms <= 5'h01;
    wait_clk(3);
    cmp_bit(terminal4_enable_signal, 1'b1);
    wr_reg(OFS_THERM, 32'd100);
    chk(16'd2250, 1'b0);
    cmp_bit(t2_inhibited, 1'b0);
    @(posedge ref_clk);
    input_terms <= 5'h00;
    // selector now disagrees with the type setting; the block only reports it
    t4_switch_voltage <= 1'b0;
    chk(16'd0, 1'b0);
    cmp_bit(t2_inhibited, 1'b1);
    rd_reg(OFS_STATUS, rd);
    cmp32(rd, 32'h000c0000);
    wr_reg(OFS_THERM, 32'h270f);
    chk(16'd5994, 1'b0);
    t2_level <= 12'h0;
    chk(16'd0, 1'b0);
    // a slow filter barely moves in four samples after a full step
    wr_reg(OFS_CTRL, 32'h8000);
    t2_level <= 12'hfff;
    wait_upd(4);
    cmp_near(freq_cmd, 16'd0, 100);
    tally_and_finish();
  end
endmodule : test_analog_frequency_command_select

bind afc_analog_cmd_sel afc_cmd_chk #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) chk (.ref_clk, .rst,
  .input_terms, .freq_cmd, .freq_reverse, .freq_update, .terminal4_enable_signal,
  .t2_inhibited);
`default_nettype wire
